// ---- src/encoder_sim_and_position_capture.sv ----
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
// What this block does
// - Format select decodes five output modes.
// - Simulated marker copies source marker unscaled.
// - Marker lock shifts phase at first marker.
// - Unlocked formats keep no marker phase.
// - Free revolution and position counters run freely.
// - Marker edge captures revolution and position.
// - Freeze and status refresh each update period.
// - Freeze stores position and sets flag in one cycle.
// - Set freeze flag blocks further freeze captures.
// - Ready bit sets once, then stays set.
// - Hold bit freezes main position outputs.
// - Faults write nonzero code, raise slot trip.
// - Drive reset clears the fault code.
// - Over 90 C forces fan, at least 10s.
// - Over 100 C trips with code 74.
// - Output motion scaled by ratio 1/32 to 1.
module encoder_sim_and_position_capture
	import encoder_sim_pkg::*;
#(
	parameter int unsigned DUMB_MODULES  = DUMB_MODULES_DEF,
	parameter int unsigned UPDATE_TICKS  = UPDATE_CYCLES,
	parameter int unsigned FAN_TICKS     = FAN_MIN_CYCLES,
	parameter int unsigned LINES_LOG2    = LINES_LOG2_DEF
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Source encoder
	input  wire logic        enc_a,
	input  wire logic        enc_b,
	input  wire logic        enc_marker,
	// Companion and drive events
	input  wire logic        freeze_event,
	input  wire logic        drive_reset,
	input  wire logic [7:0]  temp_celsius,
	// Simulated encoder output
	output logic             sim_a,
	output logic             sim_b,
	output logic             sim_marker,
	// Drive controls
	output logic             fan_full,
	output logic             drive_trip,
	output logic             slot_error_trip
);

	localparam int unsigned PERIOD_TICKS = UPDATE_TICKS * DUMB_MODULES;
	localparam int unsigned STEP_LOG2    = 14 - LINES_LOG2;   // Log2 of 1/65536-rev units per quad edge
	localparam logic [31:0] POS_STEP     = 32'h1 << STEP_LOG2;

	// Encoder decode state
	logic        prev_a;                 // Phase A one cycle back
	logic        prev_b;                 // Phase B one cycle back
	logic        prev_marker;            // Marker one cycle back
	logic        step;                   // One legal quadrature edge
	logic        step_up;                // Direction of that edge
	logic        phase_fault;            // Both phases changed at once
	logic        marker_rise;            // Marker becoming active

	// Position state
	logic [31:0] live_pos;               // {revolution, fraction}
	logic [15:0] free_revolution_count;
	logic [15:0] free_position_fraction;
	logic [15:0] marker_revolution_capture;
	logic [15:0] marker_position_capture;
	logic [15:0] freeze_revolution_capture;
	logic [15:0] freeze_position_capture;
	logic        freeze_captured_flag;
	logic        freeze_pending;         // Freeze seen since last update
	logic        feedback_ready_flag;
	logic        feedback_hold_control;
	logic [7:0]  module_fault_code;

	// Update period timer
	logic [31:0] period_count;
	logic        update_tick;

	// Simulation state
	logic [2:0]  sim_mode;
	logic [2:0]  sim_ratio;
	logic [20:0] sim_acc;                // Source edges, scaled later
	logic [15:0] sim_lin;                // Scaled output position
	logic [15:0] out_pos;                // Scaled position plus lock shift
	logic [1:0]  lock_offset;
	logic        lock_done;
	logic        sim_dir;                // Last seen direction
	logic        fmt_quad;
	logic        fmt_fwd_rev;
	logic        fmt_lock;
	logic [2:0]  ratio_used;
	logic [4:0]  sim_shift;

	// Temperature state
	logic [31:0] fan_count;
	logic        over_fan;
	logic        over_trip;

	// Bus decode
	logic        bus_setup;
	logic        bus_write;
	logic        addr_hit;

	// Encoder edge decode; inputs are synchronous to clock
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prev_a      <= 1'b0;
			prev_b      <= 1'b0;
			prev_marker <= 1'b0;
		end else begin
			prev_a      <= enc_a;
			prev_b      <= enc_b;
			prev_marker <= enc_marker;
		end
	end

	// Exactly one phase changing is a count; both is a lost edge
	assign step        = (enc_a ^ prev_a) ^ (enc_b ^ prev_b);
	assign step_up     = prev_a ^ enc_b;
	assign phase_fault = (enc_a ^ prev_a) & (enc_b ^ prev_b);
	assign marker_rise = enc_marker & ~prev_marker;

	// Free-running position, never touched by marker or freeze
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			live_pos <= 32'h0;
		end else if (step) begin
			// Fraction carries into revolutions; 32-bit wrap does both levels
			if (step_up) begin
				live_pos <= live_pos + POS_STEP;
			end else begin
				live_pos <= live_pos - POS_STEP;
			end
		end
	end

	// Update period timer
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			period_count <= 32'h0;
		end else if (period_count == 32'(PERIOD_TICKS - 1)) begin
			period_count <= 32'h0;
		end else begin
			period_count <= period_count + 32'h1;
		end
	end

	assign update_tick = (period_count == 32'(PERIOD_TICKS - 1));

	// Main position status, refreshed once per period unless held
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			free_revolution_count  <= 16'h0;
			free_position_fraction <= 16'h0;
		end else if (update_tick && !feedback_hold_control) begin
			free_revolution_count  <= live_pos[31:16];
			free_position_fraction <= live_pos[15:0];
		end
	end

	// Marker capture of the live position on each activation
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			marker_revolution_capture <= 16'h0;
			marker_position_capture   <= 16'h0;
		end else if (marker_rise) begin
			marker_revolution_capture <= live_pos[31:16];
			marker_position_capture   <= live_pos[15:0];
		end
	end

	// Freeze requests are remembered until the next update slice
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			freeze_pending <= 1'b0;
		end else if (freeze_event) begin
			// A new event in the tick cycle is kept for the next slice
			freeze_pending <= 1'b1;
		end else if (update_tick) begin
			freeze_pending <= 1'b0;
		end
	end

	// Freeze capture, only while the flag is clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			freeze_revolution_capture <= 16'h0;
			freeze_position_capture   <= 16'h0;
		end else if (update_tick && freeze_pending && !freeze_captured_flag) begin
			freeze_revolution_capture <= live_pos[31:16];
			freeze_position_capture   <= live_pos[15:0];
		end
	end

	// Freeze flag: hardware set wins over a software clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			freeze_captured_flag <= FRZ_FLAG_RESET;
		end else if (update_tick && freeze_pending && !freeze_captured_flag) begin
			freeze_captured_flag <= 1'b1;
		end else if (bus_write && paddr == OFS_FRZ_FLAG) begin
			freeze_captured_flag <= pwdata[0];
		end
	end

	// Ready comes up at the first refresh and stays until reset
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			feedback_ready_flag <= 1'b0;
		end else if (update_tick) begin
			feedback_ready_flag <= 1'b1;
		end
	end

	// Software controls
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			feedback_hold_control <= HOLD_RESET;
			sim_mode              <= SIM_MODE_RESET;
			sim_ratio             <= RATIO_RESET;
		end else if (bus_write) begin
			case (paddr)
				OFS_HOLD:      feedback_hold_control <= pwdata[0];
				OFS_SIM_MODE:  sim_mode <= pwdata[2:0];
				OFS_SIM_RATIO: sim_ratio <= pwdata[2:0];
				default: begin
					// Other offsets hold no software control
				end
			endcase
		end
	end

	// Format decode
	always_comb begin
		fmt_quad    = (sim_mode == FMT_QUAD) || (sim_mode == FMT_QUAD_LOCK);
		fmt_fwd_rev = (sim_mode == FMT_FWD_REV);
		fmt_lock    = (sim_mode >= FMT_QUAD_LOCK);
		// Modes 1 and 4 to 7 fall through to frequency and direction
	end

	// Ratio values above the top band behave as ratio 1
	assign ratio_used = (sim_ratio > RATIO_MAX) ? RATIO_MAX : sim_ratio;
	assign sim_shift  = 5'(RATIO_MAX - ratio_used);

	// Output accumulator counts source edges at full rate
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sim_acc <= 21'h0;
			sim_dir <= 1'b1;
		end else if (step) begin
			sim_dir <= step_up;
			if (step_up) begin
				sim_acc <= sim_acc + 21'h1;
			end else begin
				sim_acc <= sim_acc - 21'h1;
			end
		end
	end

	// Dividing by a power of two keeps output steps evenly spaced
	assign sim_lin = 16'(sim_acc >> sim_shift);
	assign out_pos = sim_lin + {14'h0, lock_offset};

	// Marker lock: one phase shift at the first marker in a lock mode
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lock_offset <= 2'h0;
			lock_done   <= 1'b0;
		end else if (!fmt_lock) begin
			// No defined marker phase in the plain formats
			lock_offset <= 2'h0;
			lock_done   <= 1'b0;
		end else if (marker_rise && !lock_done) begin
			// Phase 2 gives A and B high, and also F high
			lock_offset <= 2'(LOCK_PHASE - sim_lin[1:0]);
			lock_done   <= 1'b1;
		end
	end

	// Simulated outputs
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sim_a      <= 1'b0;
			sim_b      <= 1'b0;
			sim_marker <= 1'b0;
		end else begin
			// Marker passes straight through at source width
			sim_marker <= enc_marker;
			if (fmt_quad) begin
				sim_a <= out_pos[1];
				sim_b <= out_pos[1] ^ out_pos[0];
			end else if (fmt_fwd_rev) begin
				// Pulses appear on one line only, chosen by direction
				sim_a <= sim_dir & out_pos[1];
				sim_b <= ~sim_dir & out_pos[1];
			end else begin
				sim_a <= out_pos[1];
				sim_b <= sim_dir;
			end
		end
	end

	// Temperature comparisons; readings are taken as synchronous
	assign over_fan  = (temp_celsius > TEMP_FAN_C);
	assign over_trip = (temp_celsius > TEMP_TRIP_C);

	// Fan override with a least hold time
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fan_count <= 32'h0;
			fan_full  <= 1'b0;
		end else if (over_fan) begin
			fan_count <= 32'(FAN_TICKS - 1);
			fan_full  <= 1'b1;
		end else if (fan_count != 32'h0) begin
			// Keeps the fan up even if the reading dips early
			fan_count <= fan_count - 32'h1;
		end else if (temp_celsius < TEMP_FAN_C) begin
			fan_full <= 1'b0;
		end
	end

	// Fault code: a fault in the reset cycle is kept
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			module_fault_code <= FAULT_NONE;
		end else if (over_trip) begin
			module_fault_code <= FAULT_OVER_TEMP;
		end else if (phase_fault) begin
			module_fault_code <= FAULT_PHASE;
		end else if (drive_reset) begin
			module_fault_code <= FAULT_NONE;
		end
	end

	// Trip outputs follow the code one cycle later
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			slot_error_trip <= 1'b0;
			drive_trip      <= 1'b0;
		end else begin
			slot_error_trip <= (module_fault_code != FAULT_NONE);
			drive_trip      <= (module_fault_code != FAULT_NONE);
		end
	end

	// APB decode; the slave never inserts wait states
	assign bus_setup = psel & ~penable;
	assign bus_write = psel & penable & pwrite;
	assign pready    = 1'b1;

	always_comb begin
		case (paddr)
			OFS_FREE_REV, OFS_FREE_POS, OFS_MARK_REV, OFS_MARK_POS,
			OFS_FRZ_REV, OFS_FRZ_POS, OFS_FRZ_FLAG, OFS_READY,
			OFS_HOLD, OFS_FAULT, OFS_SIM_MODE, OFS_SIM_RATIO: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	// Read data and error are set up during the setup cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (bus_setup) begin
			pslverr <= ~addr_hit;
			case (paddr)
				OFS_FREE_REV:  prdata <= {16'h0, free_revolution_count};
				OFS_FREE_POS:  prdata <= {16'h0, free_position_fraction};
				OFS_MARK_REV:  prdata <= {16'h0, marker_revolution_capture};
				OFS_MARK_POS:  prdata <= {16'h0, marker_position_capture};
				OFS_FRZ_REV:   prdata <= {16'h0, freeze_revolution_capture};
				OFS_FRZ_POS:   prdata <= {16'h0, freeze_position_capture};
				OFS_FRZ_FLAG:  prdata <= {31'h0, freeze_captured_flag};
				OFS_READY:     prdata <= {31'h0, feedback_ready_flag};
				OFS_HOLD:      prdata <= {31'h0, feedback_hold_control};
				OFS_FAULT:     prdata <= {24'h0, module_fault_code};
				OFS_SIM_MODE:  prdata <= {29'h0, sim_mode};
				OFS_SIM_RATIO: prdata <= {29'h0, sim_ratio};
				// Unmapped reads return zero with an error
				default:       prdata <= 32'h0;
			endcase
		end
	end

endmodule

// ---- src/encoder_sim_pkg.sv ----
package encoder_sim_pkg;

	// Clock and update timing
	localparam int unsigned CLOCK_HZ           = 40_000_000;       // System clock rate
	localparam int unsigned UPDATE_PERIOD_MS   = 4;                // Update slice per module
	localparam int unsigned UPDATE_CYCLES      = CLOCK_HZ / 1000 * UPDATE_PERIOD_MS;
	localparam int unsigned DUMB_MODULES_DEF   = 1;                // Installed dumb modules
	localparam int unsigned FAN_MIN_S          = 10;               // Least fan override time
	localparam int unsigned FAN_MIN_CYCLES     = CLOCK_HZ * FAN_MIN_S;

	// Temperature limits in degrees C
	localparam logic [7:0]  TEMP_FAN_C         = 8'h5a;            // 90 C
	localparam logic [7:0]  TEMP_TRIP_C        = 8'h64;            // 100 C

	// Fault codes
	localparam logic [7:0]  FAULT_NONE         = 8'h00;
	localparam logic [7:0]  FAULT_OVER_TEMP    = 8'h4a;            // 74
	localparam logic [7:0]  FAULT_PHASE        = 8'h02;            // Both encoder phases moved

	// Simulation output formats
	localparam logic [2:0]  FMT_QUAD           = 3'h0;             // quadrature_format
	localparam logic [2:0]  FMT_FREQ_DIR       = 3'h1;             // freq_dir_format
	localparam logic [2:0]  FMT_FWD_REV        = 3'h2;             // fwd_rev_format
	localparam logic [2:0]  FMT_QUAD_LOCK      = 3'h3;
	localparam logic [2:0]  FMT_FREQ_LOCK_MIN  = 3'h4;             // 4 to 7 share one meaning

	// Ratio select: 0 = 1/32 ... 5 = 1
	localparam logic [2:0]  RATIO_MAX          = 3'h5;
	localparam logic [2:0]  RATIO_RESET        = 3'h3;             // 1/4
	localparam logic [1:0]  LOCK_PHASE         = 2'h2;             // Phase with A and B high

	// Source encoder resolution
	localparam int unsigned LINES_LOG2_DEF     = 12;               // 4096 lines per rev

	// Register byte offsets
	localparam logic [7:0]  OFS_FREE_REV       = 8'h00;
	localparam logic [7:0]  OFS_FREE_POS       = 8'h04;
	localparam logic [7:0]  OFS_MARK_REV       = 8'h08;
	localparam logic [7:0]  OFS_MARK_POS       = 8'h0c;
	localparam logic [7:0]  OFS_FRZ_REV        = 8'h10;
	localparam logic [7:0]  OFS_FRZ_POS        = 8'h14;
	localparam logic [7:0]  OFS_FRZ_FLAG       = 8'h18;
	localparam logic [7:0]  OFS_READY          = 8'h1c;
	localparam logic [7:0]  OFS_HOLD           = 8'h20;
	localparam logic [7:0]  OFS_FAULT          = 8'h24;
	localparam logic [7:0]  OFS_SIM_MODE       = 8'h28;
	localparam logic [7:0]  OFS_SIM_RATIO      = 8'h2c;

	// Reset values
	localparam logic [2:0]  SIM_MODE_RESET     = 3'h0;
	localparam logic        HOLD_RESET         = 1'b0;
	localparam logic        FRZ_FLAG_RESET     = 1'b0;

endpackage

// ---- tb/encoder_sim_assertions.sv ----
`timescale 1ns/10ps
module encoder_sim_checker
	import encoder_sim_pkg::*;
#(
	parameter int unsigned FAN_TICKS = FAN_MIN_CYCLES
) (
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic       enc_a,
	input wire logic       enc_b,
	input wire logic       enc_marker,
	input wire logic       drive_reset,
	input wire logic [7:0] temp_celsius,
	input wire logic       sim_marker,
	input wire logic       fan_full,
	input wire logic       drive_trip,
	input wire logic       slot_error_trip
);
	int unsigned hot_cnt;  // Cycles since temperature was last above the fan limit
	int unsigned cool_cnt; // Cycles since temperature was last at or above it

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Saturating, so a long quiet stretch cannot wrap round to a false small count
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hot_cnt  <= 0;
			cool_cnt <= 0;
		end else begin
			hot_cnt  <= (temp_celsius > TEMP_FAN_C) ? 0 : hot_cnt + (hot_cnt < FAN_TICKS + 2);
			cool_cnt <= (temp_celsius >= TEMP_FAN_C) ? 0 : cool_cnt + (cool_cnt < FAN_TICKS + 2);
		end
	end

	// Board too hot for the drive to keep running
	sequence overheat;
		temp_celsius > TEMP_TRIP_C;
	endsequence

	// Drive reset with no fault source active in the same cycle
	sequence clear_req;
		drive_reset && temp_celsius <= TEMP_TRIP_C && ($stable(enc_a) || $stable(enc_b));
	endsequence

	a_trip_pair: assert property (slot_error_trip == drive_trip)
		else $error("slot trip and drive trip disagree");
	a_trip_raise: assert property (overheat |-> ##2 (drive_trip && slot_error_trip))
		else $error("overheat did not trip within two cycles");
	a_fault_clear: assert property (clear_req |-> ##2 !slot_error_trip)
		else $error("drive reset did not clear the fault");
	a_fan_force: assert property (temp_celsius > TEMP_FAN_C |=> fan_full)
		else $error("fan not forced when hot");
	a_fan_hold: assert property ($fell(fan_full) |-> hot_cnt >= FAN_TICKS - 2)
		else $error("fan override released too early");
	a_fan_release: assert property (cool_cnt >= FAN_TICKS + 2 |-> !fan_full)
		else $error("fan override kept after cooling");
	a_marker_copy: assert property ($past(rst_b) |-> sim_marker == $past(enc_marker))
		else $error("simulated marker does not follow source");
	a_marker_width: assert property ($rose(enc_marker) ##1 enc_marker |-> sim_marker ##1 sim_marker)
		else $error("simulated marker narrower than source");
endmodule

bind encoder_sim_and_position_capture encoder_sim_checker #(.FAN_TICKS(FAN_TICKS)) u_checker (
	.clock(clock), .rst_b(rst_b), .enc_a(enc_a), .enc_b(enc_b), .enc_marker(enc_marker),
	.drive_reset(drive_reset), .temp_celsius(temp_celsius), .sim_marker(sim_marker),
	.fan_full(fan_full), .drive_trip(drive_trip), .slot_error_trip(slot_error_trip)
);

// ---- tb/encoder_source_model.sv ----
`timescale 1ns/10ps
module encoder_source_model (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic step_fwd,  // One quadrature step forward
	input  wire logic step_rev,  // One quadrature step backward
	input  wire logic step_jump, // Both phases flip at once, a broken encoder
	input  wire logic mark_req,  // Marker level wanted
	output logic      enc_a,
	output logic      enc_b,
	output logic      enc_marker
);
	logic [1:0] phase; // Position within one quadrature cycle

	// Gray coding means a healthy step flips exactly one line
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) phase <= 2'h0;
		else if (step_jump) phase <= phase + 2'h2;
		else if (step_fwd) phase <= phase + 2'h1;
		else if (step_rev) phase <= phase - 2'h1;
	end
	assign enc_a = phase[1];
	assign enc_b = phase[1] ^ phase[0];

	// Registered so the marker width equals the requested width
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) enc_marker <= 1'b0;
		else enc_marker <= mark_req;
	end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	import encoder_sim_pkg::*;
	localparam int unsigned TICKS = 20;             // Short update period
	localparam int unsigned FAN   = 30;             // Short fan override
	localparam int unsigned WAIT2 = 2 * TICKS + 4;  // Two update periods and slack
	localparam logic [4:0]  P_FWD = 5'h01, P_REV = 5'h02, P_JUMP = 5'h04;
	localparam logic [4:0]  P_FRZ = 5'h08, P_DRST = 5'h10;
	localparam logic        R = 1'b0, W = 1'b1;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_type;

	logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, rd_e, mark_req;
	logic [7:0]  paddr, temp;
	logic [31:0] pwdata, prdata, rd_q;
	logic [4:0]  ctl;  // Drive reset, freeze, jump, reverse, forward
	logic        enc_a, enc_b, enc_marker, sim_a, sim_b, sim_marker;
	logic        fan_full, drive_trip, slot_error_trip;
	int          error_cnt, tests_run;

	// Plain register traffic, inputs beside expected answers
	row_type rows [19] = '{
		'{R, OFS_READY, 32'h0, 32'h0, 1'b0}, '{R, OFS_FREE_REV, 32'h0, 32'h0, 1'b0},
		'{R, OFS_FREE_POS, 32'h0, 32'h0, 1'b0}, '{R, OFS_MARK_POS, 32'h0, 32'h0, 1'b0},
		'{R, OFS_FRZ_REV, 32'h0, 32'h0, 1'b0}, '{R, OFS_FRZ_FLAG, 32'h0, 32'h0, 1'b0},
		'{R, OFS_HOLD, 32'h0, 32'h0, 1'b0}, '{R, OFS_FAULT, 32'h0, 32'h0, 1'b0},
		'{R, OFS_SIM_RATIO, 32'h0, 32'h3, 1'b0}, '{W, OFS_FAULT, 32'h5, 32'h0, 1'b0},
		'{R, OFS_FAULT, 32'h0, 32'h0, 1'b0}, '{W, 8'h30, 32'h1, 32'h0, 1'b1},
		'{R, 8'h30, 32'h0, 32'h0, 1'b1}, '{W, OFS_HOLD, 32'h1, 32'h0, 1'b0},
		'{R, OFS_HOLD, 32'h0, 32'h1, 1'b0}, '{W, OFS_HOLD, 32'h0, 32'h0, 1'b0},
		'{W, OFS_SIM_MODE, 32'h2, 32'h0, 1'b0}, '{R, OFS_SIM_MODE, 32'h0, 32'h2, 1'b0},
		'{W, OFS_SIM_MODE, 32'h0, 32'h0, 1'b0}};

	// Power-of-two line count keeps marker lock legal
	encoder_sim_and_position_capture #(.UPDATE_TICKS(TICKS), .FAN_TICKS(FAN), .LINES_LOG2(12))
	u_encoder_sim_and_position_capture (
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enc_a(enc_a), .enc_b(enc_b), .enc_marker(enc_marker), .freeze_event(ctl[3]),
		.drive_reset(ctl[4]), .temp_celsius(temp), .sim_a(sim_a), .sim_b(sim_b),
		.sim_marker(sim_marker), .fan_full(fan_full), .drive_trip(drive_trip),
		.slot_error_trip(slot_error_trip));

	encoder_source_model u_encoder_source_model (
		.clock(clock), .rst_b(rst_b), .step_fwd(ctl[0]), .step_rev(ctl[1]),
		.step_jump(ctl[2]), .mark_req(mark_req), .enc_a(enc_a), .enc_b(enc_b),
		.enc_marker(enc_marker));

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high or 50 cycles pass
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) begin
			error_cnt++;
			$display("[FAIL] apb answer expected 1 seen 0");
		end
		rd_q = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(R, a, 32'h0);
		check(name, rd_q, exp);
	endtask

	// One-cycle pulse on the control lines
	task pulse(input logic [4:0] s);
		@(posedge clock);
		ctl <= s;
		@(posedge clock);
		ctl <= 5'h0;
	endtask

	task marker;
		@(posedge clock);
		mark_req <= 1'b1;
		repeat (3) @(posedge clock);
		mark_req <= 1'b0;
	endtask

	task final_report;
		$display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// A hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		final_report();
	end

	initial begin
		{rst_b, psel, penable, pwrite, mark_req} = 5'h0;
		{paddr, pwdata, ctl, temp} = {8'h0, 32'h0, 5'h0, 8'h19};
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) check("read data", rd_q, rows[i].q);
			check("slave error", {31'h0, rd_e}, {31'h0, rows[i].e});
		end
		rd(OFS_READY, 32'h1, "ready set");
		// Reverse past zero, then hold, then release
		pulse(P_REV);
		repeat (WAIT2) @(posedge clock);
		rd(OFS_FREE_REV, 32'hffff, "rev wrap");
		rd(OFS_FREE_POS, 32'hfffc, "pos wrap");
		apb(W, OFS_HOLD, 32'h1);
		pulse(P_FWD);
		pulse(P_FWD);
		repeat (WAIT2) @(posedge clock);
		rd(OFS_FREE_POS, 32'hfffc, "held pos");
		apb(W, OFS_HOLD, 32'h0);
		repeat (WAIT2) @(posedge clock);
		rd(OFS_FREE_REV, 32'h0, "rev unwrap");
		rd(OFS_FREE_POS, 32'h4, "pos unwrap");
		// Marker capture leaves free counters alone
		marker();
		repeat (WAIT2) @(posedge clock);
		rd(OFS_MARK_REV, 32'h0, "marker rev");
		rd(OFS_MARK_POS, 32'h4, "marker pos");
		rd(OFS_FREE_POS, 32'h4, "free pos");
		// The bench plays the companion module's freeze line
		pulse(P_FRZ);
		repeat (WAIT2) @(posedge clock);
		rd(OFS_FRZ_POS, 32'h4, "freeze pos");
		rd(OFS_FRZ_FLAG, 32'h1, "freeze flag");
		pulse(P_FWD);
		pulse(P_FRZ);
		repeat (WAIT2) @(posedge clock);
		rd(OFS_FRZ_POS, 32'h4, "freeze blocked");
		apb(W, OFS_FRZ_FLAG, 32'h0);
		pulse(P_FRZ);
		repeat (WAIT2) @(posedge clock);
		rd(OFS_FRZ_POS, 32'h8, "freeze again");
		rd(OFS_FRZ_REV, 32'h0, "freeze rev");
		// Every marker-lock format, ratio 1, finishing in quadrature lock
		apb(W, OFS_SIM_RATIO, 32'h5);
		// Odd count so the lock must really shift the phase
		pulse(P_FWD);
		for (int m = 7; m >= 3; m--) begin
			apb(W, OFS_SIM_MODE, 32'h0);
			apb(W, OFS_SIM_MODE, m);
			marker();
			@(negedge clock);
			check("sim marker", {31'h0, sim_marker}, 32'h1);
			check("lock a", {31'h0, sim_a}, 32'h1);
			if (m == 3) check("lock b", {31'h0, sim_b}, 32'h1);
		end
		pulse(P_FWD);
		repeat (3) @(posedge clock);
		check("quad step", {30'h0, sim_a, sim_b}, 32'h2);
		pulse(P_FWD);
		repeat (3) @(posedge clock);
		check("quad step", {30'h0, sim_a, sim_b}, 32'h0);
		apb(W, OFS_SIM_MODE, 32'h1);
		pulse(P_REV);
		repeat (3) @(posedge clock);
		check("direction rev", {31'h0, sim_b}, 32'h0);
		pulse(P_FWD);
		repeat (3) @(posedge clock);
		check("direction fwd", {31'h0, sim_b}, 32'h1);
		apb(W, OFS_SIM_MODE, 32'h2);
		pulse(P_FWD);
		repeat (3) @(posedge clock);
		check("fwd rev lines", {30'h0, sim_a, sim_b}, 32'h2);
		// Six source counts at ratio 1/4 are one output count
		apb(W, OFS_SIM_RATIO, 32'h3);
		repeat (3) @(posedge clock);
		check("ratio quarter", {30'h0, sim_a, sim_b}, 32'h0);
		// Phase fault, then drive reset
		pulse(P_JUMP);
		repeat (3) @(posedge clock);
		rd(OFS_FAULT, FAULT_PHASE, "phase fault");
		check("slot trip", {31'h0, slot_error_trip}, 32'h1);
		pulse(P_DRST);
		repeat (2) @(posedge clock);
		rd(OFS_FAULT, FAULT_NONE, "fault clear");
		// One hot cycle, then over-temperature with a reset that must lose
		@(posedge clock);
		temp <= 8'h5f;
		@(posedge clock);
		temp <= 8'h19;
		repeat (10) @(posedge clock);
		check("fan held", {31'h0, fan_full}, 32'h1);
		repeat (FAN + 5) @(posedge clock);
		check("fan released", {31'h0, fan_full}, 32'h0);
		temp <= 8'h65;
		repeat (3) @(posedge clock);
		check("drive trip", {31'h0, drive_trip}, 32'h1);
		pulse(P_DRST);
		repeat (2) @(posedge clock);
		rd(OFS_FAULT, FAULT_OVER_TEMP, "over temp");
		temp <= 8'h19;
		// Reset in mid-run
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rd(OFS_FAULT, FAULT_NONE, "fault after reset");
		rd(OFS_READY, 32'h0, "ready after reset");
		final_report();
	end
endmodule
